/* File: logic/ccr_consts.vh */
// constants for the cpu core register file
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH
// ******************************************
// stack
// ******************************************
`define CCR_SP_RESET 16'h00FF
`define CCR_SP_HI_BITS 10'b0000000011
`define CCR_STACK_BYTES_CALL 3'd2
`define CCR_STACK_BYTES_IRQ 3'd5
// ******************************************
// flag bit positions
// ******************************************
`define CCR_FLAG_C 0
`define CCR_FLAG_Z 1
`define CCR_FLAG_N 2
`define CCR_FLAG_I 3
`define CCR_FLAG_H 4
`define CCR_FLAGS_RESET 5'h08
// ******************************************
// apb register byte addresses
// ******************************************
`define CCR_ADDR_WORK 8'h00
`define CCR_ADDR_INDEX 8'h04
`define CCR_ADDR_FETCH 8'h08
`define CCR_ADDR_STACK 8'h0C
`define CCR_ADDR_FLAGS 8'h10
`define CCR_ADDR_CMD 8'h14
`define CCR_ADDR_OPND 8'h18
`define CCR_ADDR_STAT 8'h1C
// ******************************************
// operation codes written to the command register
// ******************************************
`define CCR_OP_NOP 5'd0
`define CCR_OP_ADD 5'd1
`define CCR_OP_ADC 5'd2
`define CCR_OP_SUB 5'd3
`define CCR_OP_SBC 5'd4
`define CCR_OP_AND 5'd5
`define CCR_OP_ORA 5'd6
`define CCR_OP_EOR 5'd7
`define CCR_OP_LDA 5'd8
`define CCR_OP_LDX 5'd9
`define CCR_OP_MUL 5'd10
`define CCR_OP_LSL 5'd11
`define CCR_OP_LSR 5'd12
`define CCR_OP_ROL 5'd13
`define CCR_OP_ROR 5'd14
`define CCR_OP_STK_INIT 5'd15
`define CCR_OP_PUSH 5'd16
`define CCR_OP_PULL 5'd17
`define CCR_OP_CALL 5'd18
`define CCR_OP_GOTO 5'd19
`define CCR_OP_BRA 5'd20
`define CCR_OP_BTB 5'd21
`define CCR_OP_BSET 5'd22
`define CCR_OP_BCLR 5'd23
`define CCR_OP_IRQ 5'd24
`define CCR_OP_RTS 5'd25
`define CCR_OP_CLI 5'd26
`define CCR_OP_SEI 5'd27
`define CCR_OP_CMP 5'd28
`define CCR_OP_TST 5'd29
`define CCR_OP_COM 5'd30
`define CCR_OP_NEG 5'd31
`endif

/* File: logic/ccr_alu.v */
// combinational alu for the cpu core register file
`timescale 1ns/100ps
`default_nettype none
`include "ccr_consts.vh"
module ccr_alu (
   // operands
   input wire [4:0] op,
   input wire [7:0] a_in,
   input wire [7:0] b_in,
   input wire c_in,
   // results
   output reg [7:0] res,
   output reg c_out,
   output reg h_out,
   output reg c_upd,
   output reg h_upd,
   output reg nz_upd
);
   reg [8:0] sum;
   reg [4:0] low;
   always @* begin
      sum = 9'h000;
      low = 5'h00;
      res = a_in;
      c_out = c_in;
      h_out = 1'b0;
      c_upd = 1'b0;
      h_upd = 1'b0;
      nz_upd = 1'b1;
      case (op)
         `CCR_OP_ADD, `CCR_OP_ADC: begin
            sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, (op == `CCR_OP_ADC) & c_in};
            low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, (op == `CCR_OP_ADC) & c_in};
            res = sum[7:0];
            c_out = sum[8];
            h_out = low[4];
            c_upd = 1'b1;
            h_upd = 1'b1;
         end
         `CCR_OP_SUB, `CCR_OP_SBC, `CCR_OP_CMP, `CCR_OP_NEG: begin
            if (op == `CCR_OP_NEG) begin
               sum = 9'h000 - {1'b0, a_in};
            end else begin
               sum = {1'b0, a_in} - {1'b0, b_in} - {8'h00, (op == `CCR_OP_SBC) & c_in};
            end
            res = sum[7:0];
            c_out = sum[8]; // borrow
            c_upd = 1'b1;
         end
         `CCR_OP_AND: res = a_in & b_in;
         `CCR_OP_ORA: res = a_in | b_in;
         `CCR_OP_EOR: res = a_in ^ b_in;
         `CCR_OP_LDA, `CCR_OP_LDX: res = b_in;
         `CCR_OP_TST: res = a_in;
         `CCR_OP_COM: begin
            res = ~a_in;
            c_out = 1'b1;
            c_upd = 1'b1;
         end
         `CCR_OP_LSL, `CCR_OP_ROL: begin
            res = {a_in[6:0], (op == `CCR_OP_ROL) & c_in};
            c_out = a_in[7];
            c_upd = 1'b1;
         end
         `CCR_OP_LSR, `CCR_OP_ROR: begin
            res = {(op == `CCR_OP_ROR) & c_in, a_in[7:1]};
            c_out = a_in[0];
            c_upd = 1'b1;
         end
         default: nz_upd = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

/* File: logic/ccr_core_regs.v */
// programming-model registers and condition flags of an 8-bit cpu core
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_consts.vh"
module ccr_core_regs (
   // clock and reset
   input wire CORE_CLK,
   input wire NRST,
   input wire CLK_EN,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   // interrupt request pin
   input wire IRQ_REQ,
   // stack and memory bus
   output reg [15:0] MEM_ADDR,
   output reg [7:0] MEM_WDATA,
   output reg MEM_WE,
   input wire [7:0] MEM_RDATA,
   // status
   output wire IRQ_TAKE
);
   // ******************************************
   // state
   // ******************************************
   localparam ST_IDLE = 2'd0;
   localparam ST_PUSH = 2'd1;
   localparam ST_PULL = 2'd2;
   reg [7:0] work_ff;
   reg [7:0] index_ff;
   reg [15:0] fetch_ff;
   reg [15:0] stack_ff;
   reg [4:0] flags_ff;
   reg [15:0] opnd_ff;
   reg [1:0] state_ff;
   reg [2:0] cnt_ff;
   reg [39:0] shift_ff;
   reg pend_ff;
   reg irq_s1_ff;
   reg irq_s2_ff;
   reg irq_q_ff;
   reg irq_prev_ff;
   reg slverr_ff;
   reg [31:0] prdata_ff;
   reg [7:0] nxt_work;
   reg [7:0] nxt_index;
   reg [15:0] nxt_fetch;
   reg [15:0] nxt_stack;
   reg [4:0] nxt_flags;
   reg [1:0] nxt_state;
   reg [2:0] nxt_cnt;
   reg [39:0] nxt_shift;
   reg nxt_pend;
   wire [7:0] alu_res;
   wire alu_c;
   wire alu_h;
   wire alu_cu;
   wire alu_hu;
   wire alu_nzu;
   wire [15:0] product;
   wire wr_en;
   wire rd_en;
   wire cmd_wr;
   wire [4:0] cmd_op;
   wire busy;
   wire addr_ok;
   // stack address is the fixed page above six pointer bits
   function [15:0] stack_addr;
      input [15:0] sp;
      begin
         stack_addr = {`CCR_SP_HI_BITS, sp[5:0]};
      end
   endfunction
   // condition test for branches: bit 3 selects flag value sense
   function cond_true;
      input [3:0] sel;
      input [4:0] f;
      begin
         case (sel[1:0])
            2'd0: cond_true = 1'b1;
            2'd1: cond_true = f[`CCR_FLAG_C];
            2'd2: cond_true = f[`CCR_FLAG_Z];
            default: cond_true = f[`CCR_FLAG_N];
         endcase
         if (sel[3]) begin
            cond_true = ~cond_true;
         end
      end
   endfunction
   // ******************************************
   // apb decode
   // ******************************************
   assign PREADY = 1'b1;
   assign wr_en = PSEL & PENABLE & PWRITE & CLK_EN;
   assign rd_en = PSEL & ~PENABLE & ~PWRITE;
   assign addr_ok = (PADDR[1:0] == 2'b00) && (PADDR <= `CCR_ADDR_STAT);
   assign cmd_wr = wr_en & addr_ok & (PADDR == `CCR_ADDR_CMD) & ~busy;
   assign cmd_op = PWDATA[4:0];
   assign busy = (state_ff != ST_IDLE);
   assign PSLVERR = slverr_ff & PSEL & PENABLE;
   assign PRDATA = prdata_ff;
   assign IRQ_TAKE = pend_ff & ~flags_ff[`CCR_FLAG_I];
   assign product = work_ff * index_ff;
   ccr_alu u_alu (
      .op(cmd_op),
      .a_in((cmd_op == `CCR_OP_LDX) ? index_ff : work_ff),
      .b_in(PWDATA[15:8]),
      .c_in(flags_ff[`CCR_FLAG_C]),
      .res(alu_res),
      .c_out(alu_c),
      .h_out(alu_h),
      .c_upd(alu_cu),
      .h_upd(alu_hu),
      .nz_upd(alu_nzu)
   );
   // ******************************************
   // next state
   // ******************************************
   always @* begin
      nxt_work = work_ff;
      nxt_index = index_ff;
      nxt_fetch = fetch_ff;
      nxt_stack = stack_ff;
      nxt_flags = flags_ff;
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_pend = pend_ff | irq_q_ff;
      MEM_ADDR = 16'h0000;
      MEM_WDATA = 8'h00;
      MEM_WE = 1'b0;
      case (state_ff)
         ST_PUSH: begin
            MEM_ADDR = stack_addr(stack_ff);
            MEM_WDATA = shift_ff[7:0];
            MEM_WE = 1'b1;
            nxt_stack = stack_ff - 16'h0001;
            nxt_shift = {8'h00, shift_ff[39:8]};
            nxt_cnt = cnt_ff - 3'd1;
            if (cnt_ff == 3'd1) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_PULL: begin
            nxt_stack = stack_ff + 16'h0001;
            MEM_ADDR = stack_addr(stack_ff + 16'h0001);
            nxt_shift = {shift_ff[31:0], MEM_RDATA};
            nxt_cnt = cnt_ff - 3'd1;
            if (cnt_ff == 3'd1) begin
               nxt_state = ST_IDLE;
               nxt_fetch = {shift_ff[7:0], MEM_RDATA};
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (!busy && IRQ_TAKE && !cmd_wr) begin
         // context order: fetch low, fetch high, index, work, flags
         nxt_shift = {3'b111, flags_ff, work_ff, index_ff, fetch_ff[15:8], fetch_ff[7:0]};
         nxt_cnt = `CCR_STACK_BYTES_IRQ;
         nxt_state = ST_PUSH;
         nxt_pend = irq_q_ff; // a new edge in the entry cycle wins
         nxt_flags[`CCR_FLAG_I] = 1'b1;
      end else if (cmd_wr) begin
         if (alu_nzu) begin
            nxt_flags[`CCR_FLAG_N] = alu_res[7];
            nxt_flags[`CCR_FLAG_Z] = (alu_res == 8'h00);
         end
         if (alu_cu) begin
            nxt_flags[`CCR_FLAG_C] = alu_c;
         end
         if (alu_hu) begin
            nxt_flags[`CCR_FLAG_H] = alu_h;
         end
         case (cmd_op)
            `CCR_OP_ADD, `CCR_OP_ADC, `CCR_OP_SUB, `CCR_OP_SBC, `CCR_OP_AND,
            `CCR_OP_ORA, `CCR_OP_EOR, `CCR_OP_LDA, `CCR_OP_LSL, `CCR_OP_LSR,
            `CCR_OP_ROL, `CCR_OP_ROR, `CCR_OP_COM, `CCR_OP_NEG: begin
               nxt_work = alu_res;
            end
            `CCR_OP_LDX: nxt_index = alu_res;
            `CCR_OP_MUL: begin
               nxt_index = product[15:8];
               nxt_work = product[7:0];
               nxt_flags[`CCR_FLAG_C] = 1'b0;
               nxt_flags[`CCR_FLAG_H] = 1'b0;
            end
            `CCR_OP_STK_INIT: nxt_stack = `CCR_SP_RESET;
            `CCR_OP_PUSH: begin
               nxt_shift = {32'h0000_0000, PWDATA[15:8]};
               nxt_cnt = 3'd1;
               nxt_state = ST_PUSH;
            end
            `CCR_OP_PULL: begin
               nxt_stack = stack_ff + 16'h0001;
               MEM_ADDR = stack_addr(stack_ff + 16'h0001);
               nxt_work = MEM_RDATA;
            end
            `CCR_OP_CALL: begin
               // target from the operand register only
               nxt_shift = {24'h00_0000, fetch_ff};
               nxt_cnt = `CCR_STACK_BYTES_CALL;
               nxt_state = ST_PUSH;
               nxt_fetch = opnd_ff;
            end
            `CCR_OP_GOTO: nxt_fetch = opnd_ff;
            `CCR_OP_BRA: begin
               // two-byte branch: skip it or add signed offset
               nxt_fetch = fetch_ff + 16'h0002;
               if (cond_true(PWDATA[19:16], flags_ff)) begin
                  nxt_fetch = fetch_ff + 16'h0002 + {{8{PWDATA[15]}}, PWDATA[15:8]};
               end
            end
            `CCR_OP_BTB: begin
               // page-zero address in [15:8], bit in [18:16]
               MEM_ADDR = {8'h00, PWDATA[15:8]};
               nxt_flags[`CCR_FLAG_C] = MEM_RDATA[PWDATA[18:16]];
               nxt_fetch = fetch_ff + 16'h0003;
               if (MEM_RDATA[PWDATA[18:16]] ^ PWDATA[19]) begin
                  nxt_fetch = fetch_ff + 16'h0003 + {{8{PWDATA[31]}}, PWDATA[31:24]};
               end
            end
            `CCR_OP_BSET, `CCR_OP_BCLR: begin
               // page-zero write, address in [31:24]
               MEM_ADDR = {8'h00, PWDATA[31:24]};
               MEM_WDATA = MEM_RDATA;
               MEM_WDATA[PWDATA[18:16]] = (cmd_op == `CCR_OP_BSET);
               MEM_WE = 1'b1;
            end
            `CCR_OP_RTS: begin
               nxt_cnt = `CCR_STACK_BYTES_CALL;
               nxt_state = ST_PULL;
            end
            `CCR_OP_CLI: nxt_flags[`CCR_FLAG_I] = 1'b0;
            `CCR_OP_SEI: nxt_flags[`CCR_FLAG_I] = 1'b1;
            `CCR_OP_IRQ: nxt_pend = 1'b1;
            default: nxt_work = work_ff;
         endcase
      end else if (wr_en && addr_ok) begin
         case (PADDR)
            `CCR_ADDR_WORK: nxt_work = PWDATA[7:0];
            `CCR_ADDR_INDEX: nxt_index = PWDATA[7:0];
            `CCR_ADDR_FETCH: nxt_fetch = PWDATA[15:0];
            `CCR_ADDR_STACK: nxt_stack = PWDATA[15:0];
            `CCR_ADDR_FLAGS: nxt_flags = PWDATA[4:0];
            default: nxt_work = work_ff;
         endcase
      end
   end
   // ******************************************
   // registers
   // ******************************************
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         work_ff <= 8'h00;
         index_ff <= 8'h00;
         fetch_ff <= 16'h0000;
         stack_ff <= `CCR_SP_RESET;
         flags_ff <= `CCR_FLAGS_RESET;
         opnd_ff <= 16'h0000;
         state_ff <= ST_IDLE;
         cnt_ff <= 3'd0;
         shift_ff <= 40'h00_0000_0000;
         pend_ff <= 1'b0;
         irq_s1_ff <= 1'b0;
         irq_s2_ff <= 1'b0;
         irq_q_ff <= 1'b0;
         slverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else if (CLK_EN) begin
         work_ff <= nxt_work;
         index_ff <= nxt_index;
         fetch_ff <= nxt_fetch;
         stack_ff <= nxt_stack;
         flags_ff <= nxt_flags;
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         pend_ff <= nxt_pend;
         irq_s1_ff <= IRQ_REQ;
         irq_s2_ff <= irq_s1_ff;
         // rising edge only, so a held pin is one request
         irq_q_ff <= irq_s2_ff & ~irq_prev_ff;
         if (wr_en && addr_ok && PADDR == `CCR_ADDR_OPND) begin
            opnd_ff <= PWDATA[15:0];
         end
         if (rd_en) begin
            slverr_ff <= ~addr_ok;
            case (PADDR)
               `CCR_ADDR_WORK: prdata_ff <= {24'h00_0000, work_ff};
               `CCR_ADDR_INDEX: prdata_ff <= {24'h00_0000, index_ff};
               `CCR_ADDR_FETCH: prdata_ff <= {16'h0000, fetch_ff};
               `CCR_ADDR_STACK: prdata_ff <= {16'h0000, stack_ff};
               `CCR_ADDR_FLAGS: prdata_ff <= {27'h000_0000, flags_ff};
               `CCR_ADDR_OPND: prdata_ff <= {16'h0000, opnd_ff};
               `CCR_ADDR_STAT: prdata_ff <= {29'h0000_0000, pend_ff, busy, cnt_ff != 3'd0};
               default: prdata_ff <= 32'h0000_0000;
            endcase
         end else if (PSEL && !PENABLE) begin
            // any other setup drops a stale error from an earlier read
            slverr_ff <= 1'b0;
         end
      end
   end
   // previous synchronised level for the edge detector
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_prev_ff <= 1'b0;
      end else if (CLK_EN) begin
         irq_prev_ff <= irq_s2_ff;
      end
   end
endmodule
`default_nettype wire

/* File: test/ccr_mem_model.sv */
// behavioural page-zero memory that answers the core's memory port
`timescale 1ns/100ps
`default_nettype none
module ccr_mem_model (
   // clock
   input wire logic clk,
   // core memory port
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_we,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:255];
   // known contents, non-zero except at address 8'h5A, so bit ops see real data
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = i[7:0] ^ 8'h5A;
      end
   end
   always @(posedge clk) begin
      if (mem_we) begin
         mem[mem_addr[7:0]] <= mem_wdata;
      end
   end
   // outside page zero nothing answers: address-dependent junk
   assign mem_rdata = (mem_addr[15:8] == 8'h00) ? mem[mem_addr[7:0]] : ~mem_addr[7:0];
endmodule
`default_nettype wire

/* File: test/ccr_core_regs_chk.sv */
// port-level assertions for the cpu core register file
`timescale 1ns/100ps
`default_nettype none
module ccr_core_regs_chk (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // memory and interrupt
   input wire logic [15:0] MEM_ADDR,
   input wire logic MEM_WE,
   input wire logic IRQ_TAKE
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);
   sequence s_stack_push;
      MEM_WE && (MEM_ADDR[15:6] == 10'h003);
   endsequence
   sequence s_read_setup;
      PSEL && !PENABLE && !PWRITE;
   endsequence
   a_slverr_read: assert property (PSLVERR |-> PSEL && PENABLE && !PWRITE)
      else $error("error response outside a read access");
   a_zero_wait: assert property (PSEL && PENABLE |-> PREADY)
      else $error("access phase not answered at once");
   a_data_stands: assert property (!$stable(PRDATA) |-> $past(PSEL && !PENABLE && !PWRITE))
      else $error("read data changed without a read setup");
   a_write_page0: assert property (MEM_WE |-> MEM_ADDR[15:8] == 8'h00)
      else $error("memory write outside page zero");
   a_push_down: assert property (s_stack_push ##1 s_stack_push |->
      MEM_ADDR[5:0] == $past(MEM_ADDR[5:0]) - 6'h01)
      else $error("consecutive pushes not one byte lower");
   a_take_stacks: assert property ($rose(IRQ_TAKE) |-> ##[0:16] s_stack_push)
      else $error("interrupt taken without stacking");
   a_take_ends: assert property ($rose(IRQ_TAKE) |-> ##[1:32] !IRQ_TAKE)
      else $error("interrupt entry did not mask further requests");
   a_mask_reset: assert property (!$past(NRST) |-> !IRQ_TAKE)
      else $error("interrupt taken right after reset");
   c_read: cover property (s_read_setup ##1 PENABLE);
endmodule
bind ccr_core_regs ccr_core_regs_chk i_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .MEM_ADDR(MEM_ADDR), .MEM_WE(MEM_WE), .IRQ_TAKE(IRQ_TAKE));
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the cpu core register file
`timescale 1ns/100ps
`default_nettype none
`include "ccr_consts.vh"
module tb;
   logic core_clk, nrst, psel, penable, pwrite, irq_req, pready, pslverr, irq_take, mem_we;
   logic [7:0] paddr, mem_wdata, mem_rdata, a, b;
   logic [31:0] pwdata, prdata, rd_d, lfsr;
   logic [15:0] mem_addr, p;
   logic [8:0] s;
   logic [4:0] hs, op;
   logic ci, cie, clk_en;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   int n_fail, samples_checked, n_wr, w0;
   // ******************************************
   // instances
   // ******************************************
   ccr_core_regs i_ccr_core_regs (.CORE_CLK(core_clk), .NRST(nrst), .CLK_EN(clk_en),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ_REQ(irq_req),
      .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WE(mem_we), .MEM_RDATA(mem_rdata),
      .IRQ_TAKE(irq_take));
   ccr_mem_model i_ccr_mem_model (.clk(core_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_we(mem_we), .mem_rdata(mem_rdata));
   // ******************************************
   // helpers
   // ******************************************
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] nxt_rand(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic summarize();
      $display("counts: %0d checked, %0d mismatched", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one transfer; ex = {data compared, error expected, data}
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
      input logic [33:0] ex);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      if (!wr) begin
         exp_q.push_back(ex);
      end
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         summarize();
      end
      rd_d = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [33:0] ex);
      apb(1'b0, ad, 32'h0000_0000, ex);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      apb(1'b1, ad, wd, 34'h0);
   endtask
   // command, then poll the busy bit; commands wait for an idle core
   task automatic cmd(input logic [4:0] o, input logic [7:0] opnd, input logic [3:0] sel,
      input logic [7:0] ad);
      int k;
      wr(`CCR_ADDR_CMD, {ad, 4'h0, sel, opnd, 3'h0, o});
      k = 0;
      do begin
         rd(`CCR_ADDR_STAT, 34'h0);
         k++;
      end while (rd_d[1] !== 1'b0 && k < 100);
      if (rd_d[1] !== 1'b0) begin
         n_fail++;
         summarize();
      end
   endtask
   // ******************************************
   // read monitor and write counter
   // ******************************************
   always @(posedge core_clk) begin
      if (psel && penable && !pwrite && pready) begin
         e = exp_q.pop_front();
         if (e[33]) begin
            chk(prdata, e[31:0]);
         end
         chk({31'h0, pslverr}, {31'h0, e[32]});
      end
      if (nrst && mem_we) begin
         n_wr <= n_wr + 1;
      end
   end
   // ******************************************
   // main sequence
   // ******************************************
   initial begin
      {nrst, psel, penable, pwrite, irq_req, paddr, pwdata} = '0;
      clk_en = 1'b1;
      lfsr = 32'h825c_73a1;
      n_fail = 0;
      samples_checked = 0;
      n_wr = 0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      rd(`CCR_ADDR_WORK, {2'h2, 32'h0000_0000});
      rd(`CCR_ADDR_INDEX, {2'h2, 32'h0000_0000});
      rd(`CCR_ADDR_STACK, {2'h2, 32'h0000_00FF});
      rd(`CCR_ADDR_FLAGS, {2'h2, 32'h0000_0008});
      // a frozen core must ignore a write
      clk_en <= 1'b0;
      wr(`CCR_ADDR_WORK, 32'h0000_0055);
      clk_en <= 1'b1;
      rd(`CCR_ADDR_WORK, {2'h2, 32'h0000_0000});
      rd(8'h20, {2'h1, 32'h0000_0000});
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         lfsr = nxt_rand(lfsr);
         a = (i == 0) ? 8'h88 : lfsr[7:0];
         b = (i == 0) ? 8'h78 : lfsr[15:8];
         ci = lfsr[16];
         op = i[0] ? `CCR_OP_ADC : `CCR_OP_ADD;
         cie = i[0] & ci;
         wr(`CCR_ADDR_WORK, {24'h0, a});
         wr(`CCR_ADDR_FLAGS, {27'h0, 4'h4, ci});
         cmd(op, b, 4'h0, 8'h00);
         s = {1'b0, a} + {1'b0, b} + {8'h0, cie};
         hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cie};
         rd(`CCR_ADDR_WORK, {2'h2, 24'h0, s[7:0]});
         hs = {hs[4], 1'b1, s[7], s[7:0] == 8'h00, s[8]};
         rd(`CCR_ADDR_FLAGS, {2'h2, 27'h0, hs});
      end
      $display("test add done");
      lfsr = nxt_rand(lfsr);
      wr(`CCR_ADDR_WORK, {24'h0, lfsr[7:0]});
      wr(`CCR_ADDR_INDEX, {24'h0, lfsr[15:8]});
      wr(`CCR_ADDR_FLAGS, 32'h0000_0019);
      cmd(`CCR_OP_MUL, 8'h00, 4'h0, 8'h00);
      p = {8'h0, lfsr[7:0]} * {8'h0, lfsr[15:8]};
      rd(`CCR_ADDR_INDEX, {2'h2, 24'h0, p[15:8]});
      rd(`CCR_ADDR_WORK, {2'h2, 24'h0, p[7:0]});
      rd(`CCR_ADDR_FLAGS, {2'h2, 32'h0000_0008});
      $display("test multiply done");
      cmd(`CCR_OP_STK_INIT, 8'h00, 4'h0, 8'h00);
      rd(`CCR_ADDR_STACK, {2'h2, 32'h0000_00FF});
      cmd(`CCR_OP_PUSH, 8'h00, 4'h0, 8'h00);
      rd(`CCR_ADDR_STACK, {2'h2, 32'h0000_00FE});
      cmd(`CCR_OP_PULL, 8'h00, 4'h0, 8'h00);
      rd(`CCR_ADDR_STACK, {2'h2, 32'h0000_00FF});
      // a full window of pushes must land back on the same slot
      repeat (64) cmd(`CCR_OP_PUSH, 8'h00, 4'h0, 8'h00);
      rd(`CCR_ADDR_STACK, 34'h0);
      chk({26'h0, rd_d[5:0]}, 32'h0000_003F);
      $display("test stack done");
      cmd(`CCR_OP_STK_INIT, 8'h00, 4'h0, 8'h00);
      wr(`CCR_ADDR_OPND, 32'h0000_1234);
      wr(`CCR_ADDR_FETCH, 32'h0000_0ABC);
      w0 = n_wr;
      cmd(`CCR_OP_CALL, 8'h00, 4'h0, 8'h00);
      rd(`CCR_ADDR_FETCH, {2'h2, 32'h0000_1234});
      rd(`CCR_ADDR_STACK, {2'h2, 32'h0000_00FD});
      chk(32'(n_wr - w0), 32'h0000_0002);
      chk({16'h0, i_ccr_mem_model.mem[254], i_ccr_mem_model.mem[255]},
         32'h0000_0ABC);
      cmd(`CCR_OP_RTS, 8'h00, 4'h0, 8'h00);
      rd(`CCR_ADDR_FETCH, {2'h2, 32'h0000_0ABC});
      rd(`CCR_ADDR_STACK, {2'h2, 32'h0000_00FF});
      wr(`CCR_ADDR_FETCH, 32'h0000_0100);
      wr(`CCR_ADDR_FLAGS, 32'h0000_0008);
      cmd(`CCR_OP_BRA, 8'h10, 4'h1, 8'h00);
      rd(`CCR_ADDR_FETCH, {2'h2, 32'h0000_0102});
      cmd(`CCR_OP_BRA, 8'h10, 4'h0, 8'h00);
      rd(`CCR_ADDR_FETCH, {2'h2, 32'h0000_0114});
      $display("test call and branch done");
      cmd(`CCR_OP_BTB, 8'h40, 4'h1, 8'h40);
      rd(`CCR_ADDR_FLAGS, {2'h2, 32'h0000_0009});
      rd(`CCR_ADDR_FETCH, {2'h2, 32'h0000_0157});
      cmd(`CCR_OP_BTB, 8'h40, 4'h0, 8'h40);
      rd(`CCR_ADDR_FLAGS, {2'h2, 32'h0000_0008});
      cmd(`CCR_OP_BSET, 8'h00, 4'h0, 8'h40);
      chk({24'h0, i_ccr_mem_model.mem[64]}, 32'h0000_001B);
      cmd(`CCR_OP_BCLR, 8'h00, 4'h1, 8'h40);
      chk({24'h0, i_ccr_mem_model.mem[64]}, 32'h0000_0019);
      $display("test bit ops done");
      cmd(`CCR_OP_STK_INIT, 8'h00, 4'h0, 8'h00);
      wr(`CCR_ADDR_FLAGS, 32'h0000_0008);
      w0 = n_wr;
      irq_req <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd(`CCR_ADDR_STAT, 34'h0);
      chk({31'h0, rd_d[2]}, 32'h0000_0001);
      chk({31'h0, irq_take}, 32'h0000_0000);
      rd(`CCR_ADDR_STACK, {2'h2, 32'h0000_00FF});
      cmd(`CCR_OP_CLI, 8'h00, 4'h0, 8'h00);
      cmd(`CCR_OP_NOP, 8'h00, 4'h0, 8'h00);
      rd(`CCR_ADDR_STACK, {2'h2, 32'h0000_00FA});
      chk(32'(n_wr - w0), 32'h0000_0005);
      rd(`CCR_ADDR_FLAGS, 34'h0);
      chk({31'h0, rd_d[3]}, 32'h0000_0001);
      irq_req <= 1'b0;
      $display("test interrupt done");
      summarize();
   end
endmodule
`default_nettype wire
